// file: hw/rtcta_defines.vh
`ifndef RTCTA_DEFINES_VH
`define RTCTA_DEFINES_VH

// register byte offsets
`define RTCTA_OFF_CTRL 5'h00
`define RTCTA_OFF_TIME 5'h04
`define RTCTA_OFF_ALM1 5'h08
`define RTCTA_OFF_ALM2 5'h0C
`define RTCTA_OFF_SWCH 5'h10
`define RTCTA_OFF_STAT 5'h14
`define RTCTA_OFF_MASK 5'h18
`define RTCTA_OFF_WAKE 5'h1C

// control bits
`define RTCTA_CTRL_ALM1 0
`define RTCTA_CTRL_ALM2 1
`define RTCTA_CTRL_SWEN 2
`define RTCTA_CTRL_W 3

// event bits of status, mask and wake registers
`define RTCTA_EV_SEC 0
`define RTCTA_EV_MIN 1
`define RTCTA_EV_DAY 2
`define RTCTA_EV_AL1 3
`define RTCTA_EV_AL2 4
`define RTCTA_EV_SW 5
`define RTCTA_EV_W 6

// time word layout
`define RTCTA_SEC_RNG 5:0
`define RTCTA_MIN_RNG 13:8
`define RTCTA_HR_RNG 20:16
`define RTCTA_DAY_RNG 31:24
`define RTCTA_TOD_RNG 20:0
`define RTCTA_ALM1_MASK 32'h001F3F3F
`define RTCTA_ALM2_MASK 32'hFF1F3F3F
`define RTCTA_SW_W 16

// wrap limits
`define RTCTA_SEC_MAX 6'h3B
`define RTCTA_MIN_MAX 6'h3B
`define RTCTA_HR_MAX 5'h17

// crystal rate in hz, and the tick it gives
`define RTCTA_XTAL_HZ 32768
`define RTCTA_TICK_HZ 1

`endif

// file: hw/rtcta_top.v
// Function
// RL1: crystal divided by prescaler gives 1 Hz tick
// RL2: seconds, minutes, hours, day counters cascaded
// RL3: periodic interrupts per second, minute, day
// RL4: enabled alarm interrupts on counter match
// RL5: daily time alarm plus day-and-time alarm
// RL6: stopwatch loads count, decrements each minute
// RL7: enabled stopwatch interrupts on underflow only
// RL8: every interrupt source usable as wake-up
// RL9: keeps counting regardless of processor power
// RL10: 59 and 23 wrap, carry into next
// RL11: sticky status flags, masked interrupt output
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rtcta_defines.vh"

module rtcta_top #(
    parameter PRESCALE = `RTCTA_XTAL_HZ / `RTCTA_TICK_HZ
) (
    input wire clk, // 10 MHz system clock
    input wire rst_n, // async reset, active low
    input wire xtal_in, // 32.768 kHz crystal clock level
    input wire psel, // apb select
    input wire penable, // apb enable
    input wire pwrite, // apb direction
    input wire [4:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error on unmapped address
    output reg irq, // level interrupt
    output reg wake // level wake-up request
);

    // prescaler width; PRESCALE - 1 must fit, so at most 65536
    // crystal edges per tick. a wider prescaler needs PW raised
    // together with PRESCALE, otherwise the compare value is cut.
    localparam PW = 16;

    // crystal synchroniser and edge detect
    reg xtal_s1_r; // first sync stage
    reg xtal_s2_r; // second sync stage
    reg xtal_s3_r; // delayed copy for edge detect
    wire xedge; // rising crystal edge, one clk wide

    // prescaler and one-second tick
    reg [PW-1:0] pre_r; // crystal edge count
    reg tick_r; // one-second tick

    // timekeeping counters
    reg [5:0] sec_r; // seconds 0..59
    reg [5:0] min_r; // minutes 0..59
    reg [4:0] hr_r; // hours 0..23
    reg [7:0] day_r; // day count, wraps silently
    wire [31:0] time_w; // packed time word

    // software registers
    reg [`RTCTA_CTRL_W-1:0] ctrl_r; // alarm and stopwatch enables
    reg [31:0] alm1_r; // time-of-day alarm
    reg [31:0] alm2_r; // day-and-time alarm
    reg [`RTCTA_SW_W-1:0] sw_r; // stopwatch count
    reg [`RTCTA_EV_W-1:0] stat_r; // sticky event flags
    reg [`RTCTA_EV_W-1:0] mask_r; // interrupt enables
    reg [`RTCTA_EV_W-1:0] wken_r; // wake-up enables

    // events
    reg al1_d_r; // alarm 1 matched last cycle
    reg al2_d_r; // alarm 2 matched last cycle
    wire sec_ev; // second elapsed
    wire min_ev; // minute elapsed
    wire day_ev; // day elapsed
    wire sw_dec; // stopwatch decrement strobe
    wire sw_unf; // stopwatch underflow
    wire al1_hit; // alarm 1 matches now
    wire al2_hit; // alarm 2 matches now
    wire [`RTCTA_EV_W-1:0] ev; // one-cycle event vector

    // bus decode
    wire wr_en; // write lands at this edge
    wire rd_phase; // first access cycle
    wire mapped; // word-aligned address
    wire wr_time; // time word write
    wire wr_swch; // stopwatch load
    wire wr_stat; // status write-one-to-clear
    reg [31:0] rdata_nxt; // read mux output
    genvar gi; // status bit index

    // crystal level through two flops, third for edge detect
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_s1_r <= 1'b0;
            xtal_s2_r <= 1'b0;
            xtal_s3_r <= 1'b0;
        end else begin
            xtal_s1_r <= xtal_in;
            xtal_s2_r <= xtal_s1_r;
            xtal_s3_r <= xtal_s2_r;
        end
    end
    assign xedge = xtal_s2_r & ~xtal_s3_r;

    // prescaler: one tick per PRESCALE crystal edges
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_r <= {PW{1'b0}};
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (xedge) begin
                if (pre_r == PRESCALE[PW-1:0] - 1'b1) begin // [RL1]
                    pre_r <= {PW{1'b0}};
                    tick_r <= 1'b1; // [RL1]
                end else begin
                    pre_r <= pre_r + 1'b1;
                end
            end
        end
    end

    // cascade events
    assign sec_ev = tick_r; // [RL3]
    assign min_ev = tick_r && (sec_r == `RTCTA_SEC_MAX); // [RL10]
    assign day_ev = min_ev && (min_r == `RTCTA_MIN_MAX)
                    && (hr_r == `RTCTA_HR_MAX); // [RL10]

    // apb handshake terms
    assign wr_en = psel & penable & pready & pwrite;
    assign rd_phase = psel & penable & ~pready;
    assign mapped = (paddr[1:0] == 2'h0);

    // per-register write strobes, only on the answering edge
    assign wr_time = wr_en && (paddr == `RTCTA_OFF_TIME);
    assign wr_swch = wr_en && (paddr == `RTCTA_OFF_SWCH);
    assign wr_stat = wr_en && (paddr == `RTCTA_OFF_STAT);

    // time counters, software write of the time word wins
    // a tick in the same cycle as a time write is lost on purpose:
    // software sets the time it wants, not that time plus one second
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sec_r <= 6'h00;
            min_r <= 6'h00;
            hr_r <= 5'h00;
            day_r <= 8'h00;
        end else if (wr_time) begin
            sec_r <= pwdata[`RTCTA_SEC_RNG];
            min_r <= pwdata[`RTCTA_MIN_RNG];
            hr_r <= pwdata[`RTCTA_HR_RNG];
            day_r <= pwdata[`RTCTA_DAY_RNG];
        end else if (tick_r) begin // [RL2] [RL9]
            sec_r <= min_ev ? 6'h00 : sec_r + 6'h01; // [RL10]
            if (min_ev) begin
                min_r <= (min_r == `RTCTA_MIN_MAX) ? 6'h00
                         : min_r + 6'h01; // [RL10]
                if (min_r == `RTCTA_MIN_MAX)
                    hr_r <= (hr_r == `RTCTA_HR_MAX) ? 5'h00
                            : hr_r + 5'h01; // [RL10]
            end
            if (day_ev)
                day_r <= day_r + 8'h01; // [RL10]
        end
    end

    assign time_w = {day_r, 3'h0, hr_r, 2'h0, min_r, 2'h0, sec_r};

    // alarm compare after the counters settle, one pulse per match
    // a match lasts a whole second, so the delayed copy keeps the
    // flag from being set again on every clock of that second
    assign al1_hit = ctrl_r[`RTCTA_CTRL_ALM1] &&
        (time_w[`RTCTA_TOD_RNG] == alm1_r[`RTCTA_TOD_RNG]); // [RL4] [RL5]
    assign al2_hit = ctrl_r[`RTCTA_CTRL_ALM2] &&
        (time_w == alm2_r); // [RL4] [RL5]
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            al1_d_r <= 1'b0;
            al2_d_r <= 1'b0;
        end else begin
            al1_d_r <= al1_hit;
            al2_d_r <= al2_hit;
        end
    end

    // stopwatch: minute countdown, underflow wraps to all ones
    // a disabled stopwatch neither counts nor flags
    assign sw_dec = ctrl_r[`RTCTA_CTRL_SWEN] && min_ev; // [RL6]
    assign sw_unf = sw_dec && (sw_r == {`RTCTA_SW_W{1'b0}}); // [RL7]
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            sw_r <= {`RTCTA_SW_W{1'b0}};
        else if (wr_swch)
            sw_r <= pwdata[`RTCTA_SW_W-1:0]; // [RL6]
        else if (sw_dec)
            sw_r <= sw_r - 1'b1; // [RL6]
    end

    // event vector
    assign ev = {sw_unf, al2_hit & ~al2_d_r, al1_hit & ~al1_d_r,
                 day_ev, min_ev, sec_ev};

    // control, alarm, mask and wake registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= {`RTCTA_CTRL_W{1'b0}};
            alm1_r <= 32'h00000000;
            alm2_r <= 32'h00000000;
            mask_r <= {`RTCTA_EV_W{1'b0}};
            wken_r <= {`RTCTA_EV_W{1'b0}};
        end else if (wr_en) begin
            case (paddr)
                `RTCTA_OFF_CTRL: ctrl_r <= pwdata[`RTCTA_CTRL_W-1:0];
                `RTCTA_OFF_ALM1: alm1_r <= pwdata & `RTCTA_ALM1_MASK;
                `RTCTA_OFF_ALM2: alm2_r <= pwdata & `RTCTA_ALM2_MASK;
                `RTCTA_OFF_MASK: mask_r <= pwdata[`RTCTA_EV_W-1:0];
                `RTCTA_OFF_WAKE: wken_r <= pwdata[`RTCTA_EV_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky status, write one to clear, set beats clear
    // the event is tested first so that a clear landing in the
    // same cycle as a new event never loses that event
    generate
        for (gi = 0; gi < `RTCTA_EV_W; gi = gi + 1) begin : g_stat
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    stat_r[gi] <= 1'b0;
                else if (ev[gi])
                    stat_r[gi] <= 1'b1; // [RL11]
                else if (wr_stat && pwdata[gi])
                    stat_r[gi] <= 1'b0; // [RL11]
            end
        end
    endgenerate

    // interrupt and wake outputs
    // both registered, one cycle behind the status flags
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq <= |(stat_r & mask_r); // [RL11] [RL3]
            wake <= |(stat_r & wken_r); // [RL8]
        end
    end

    // read mux
    always @* begin
        rdata_nxt = 32'h00000000;
        case (paddr)
            `RTCTA_OFF_CTRL: rdata_nxt[`RTCTA_CTRL_W-1:0] = ctrl_r;
            `RTCTA_OFF_TIME: rdata_nxt = time_w;
            `RTCTA_OFF_ALM1: rdata_nxt = alm1_r;
            `RTCTA_OFF_ALM2: rdata_nxt = alm2_r;
            `RTCTA_OFF_SWCH: rdata_nxt[`RTCTA_SW_W-1:0] = sw_r;
            `RTCTA_OFF_STAT: rdata_nxt[`RTCTA_EV_W-1:0] = stat_r;
            `RTCTA_OFF_MASK: rdata_nxt[`RTCTA_EV_W-1:0] = mask_r;
            `RTCTA_OFF_WAKE: rdata_nxt[`RTCTA_EV_W-1:0] = wken_r;
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // apb slave: ready one cycle into the access phase
    // ready is a single-cycle pulse; the ~pready term in rd_phase
    // drops it after one cycle, so a held access answers every other cycle
    // read data is captured with ready and then held until the
    // next read, so a slow master still sees a stable word
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= rd_phase;
            pslverr <= rd_phase & ~mapped;
            if (rd_phase && !pwrite)
                prdata <= rdata_nxt;
        end
    end

endmodule // rtcta_top
`default_nettype wire

// file: sim/rtc_time_alarm_stopwatch_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcta_defines.vh"
module rtc_time_alarm_stopwatch_test;
    reg clk = 1'h0, rst_n = 1'h0, xtal = 1'h0, err = 1'h0;
    reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    reg [4:0] paddr = 5'h0;
    reg [31:0] pwdata = 32'h0, rd = 32'h0;
    reg [2:0] xc = 3'h0;
    wire [31:0] prdata;
    wire pready, pslverr, irq, wake;
    integer n_mismatch = 0, n_tests = 0;
    always #50 clk = ~clk;
    // crystal stand-in, eight clocks a period
    always @(posedge clk) begin
        xc <= xc + 3'h1;
        xtal <= xc[2];
    end
    rtcta_top #(.PRESCALE(4)) DUT (.clk(clk), .rst_n(rst_n), .xtal_in(xtal),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .wake(wake));
    task print_verdict;
        begin
            if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // one apb transfer, then an idle edge
    task xfer(input w, input [4:0] a, input [31:0] d);
        integer k;
        begin
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk) penable <= 1'h1;
            @(posedge clk);
            for (k = 0; pready !== 1'h1; k = k + 1) begin
                if (k > 20) begin cmp(k, 0); print_verdict; end
                @(posedge clk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'h0;
            penable <= 1'h0;
            @(posedge clk);
        end
    endtask
    // read until all bits of m are set
    task poll(input [4:0] a, input [31:0] m);
        integer k;
        begin
            rd = 32'h0;
            for (k = 0; (rd & m) !== m; k = k + 1) begin
                if (k > 2000) begin cmp(rd, m); print_verdict; end
                xfer(1'h0, a, 32'h0);
            end
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        xfer(1'h0, `RTCTA_OFF_STAT, 32'h0); cmp(rd, 32'h0);
        xfer(1'h1, 5'h19, 32'hFFFFFFFF); cmp({31'h0, err}, 32'h1);
        xfer(1'h0, 5'h1A, 32'h0); cmp(rd, 32'h0);
        cmp({31'h0, err}, 32'h1);
        xfer(1'h1, `RTCTA_OFF_ALM2, 32'hFFFFFFFF);
        xfer(1'h0, `RTCTA_OFF_ALM2, 32'h0); cmp(rd, `RTCTA_ALM2_MASK);
        xfer(1'h0, `RTCTA_OFF_MASK, 32'h0); cmp(rd, 32'h0);
        // day rollover from day 5, 23:59:58
        xfer(1'h1, `RTCTA_OFF_TIME, 32'h05173B3A);
        xfer(1'h1, `RTCTA_OFF_STAT, 32'h3F);
        poll(`RTCTA_OFF_STAT, 32'h4); cmp(rd & 32'h7, 32'h7);
        xfer(1'h0, `RTCTA_OFF_TIME, 32'h0); cmp(rd, 32'h06000000);
        // both alarms at day 6, 00:00:03
        xfer(1'h1, `RTCTA_OFF_ALM1, 32'h00000003);
        xfer(1'h1, `RTCTA_OFF_ALM2, 32'h06000003);
        xfer(1'h1, `RTCTA_OFF_MASK, 32'h18);
        xfer(1'h1, `RTCTA_OFF_CTRL, 32'h3);
        poll(`RTCTA_OFF_STAT, 32'h18); cmp({31'h0, irq}, 32'h1);
        xfer(1'h0, `RTCTA_OFF_TIME, 32'h0); cmp(rd, 32'h06000003);
        xfer(1'h1, `RTCTA_OFF_STAT, 32'h3F);
        @(posedge clk);
        cmp({31'h0, irq}, 32'h0);
        // wake follows the seconds flag once enabled
        cmp({31'h0, wake}, 32'h0);
        xfer(1'h1, `RTCTA_OFF_WAKE, 32'h1);
        poll(`RTCTA_OFF_STAT, 32'h1); cmp({31'h0, wake}, 32'h1);
        // stopwatch from 1: zero after a minute, underflow after two
        xfer(1'h1, `RTCTA_OFF_SWCH, 32'h1);
        xfer(1'h1, `RTCTA_OFF_CTRL, 32'h4);
        xfer(1'h1, `RTCTA_OFF_MASK, 32'h20);
        xfer(1'h1, `RTCTA_OFF_STAT, 32'h3F);
        poll(`RTCTA_OFF_STAT, 32'h2); cmp(rd & 32'h20, 32'h0);
        xfer(1'h0, `RTCTA_OFF_SWCH, 32'h0); cmp(rd, 32'h0);
        poll(`RTCTA_OFF_STAT, 32'h20); cmp({31'h0, irq}, 32'h1);
        xfer(1'h0, `RTCTA_OFF_SWCH, 32'h0); cmp(rd, 32'hFFFF);
        // disabled stopwatch stays frozen and quiet
        xfer(1'h1, `RTCTA_OFF_CTRL, 32'h0);
        xfer(1'h1, `RTCTA_OFF_STAT, 32'h3F);
        poll(`RTCTA_OFF_STAT, 32'h2); cmp(rd & 32'h20, 32'h0);
        xfer(1'h0, `RTCTA_OFF_SWCH, 32'h0); cmp(rd, 32'hFFFF);
        print_verdict;
    end
endmodule // rtc_time_alarm_stopwatch_test
`default_nettype wire

// file: sim/rtcta_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rtcta_sva (
    input wire clk, // clock
    input wire rst_n, // reset, active low
    input wire psel, // select
    input wire penable, // enable
    input wire pwrite, // direction
    input wire [4:0] paddr, // address
    input wire [31:0] prdata, // read data
    input wire pready, // ready
    input wire pslverr, // error
    input wire irq // interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // bus answer timing and framing
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_time: assert property ($rose(penable) |=> pready)
        else $error("ready late");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    // refusal of unaligned words, and read data hold
    a_err_pair: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_odd: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned not refused");
    a_err_even: assert property (pready && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("aligned refused");
    a_odd_zero: assert property (pready && !pwrite && paddr[1:0] != 2'h0
        |-> prdata == 32'h0)
        else $error("unaligned read not zero");
    a_rdata_hold: assert property (!(psel && penable && !pwrite && !pready)
        |=> $stable(prdata))
        else $error("read data moved");
    // main scenarios
    c_refused: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
    c_stat_read: cover property (pready && !pwrite && paddr == 5'h14);
endmodule // rtcta_sva
bind rtcta_top rtcta_sva u_sva (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire
